// >>> bench/lrbs_solver_test.sv
// self-checking bench for the rung solver against an integer model
`timescale 1ns/1ns
`default_nettype none
module lrbs_solver_test;
	import lrbs_pkg::*;
	localparam int WN = 16;
	logic                    i_clk;
	logic                    i_rst_b;
	lrbs_instr_t             i_instr;
	lrbs_wr_t                o_wr;
	logic                    o_rung_result;
	logic [LRBS_DEPTH_W-1:0] o_stack_depth;
	logic                    o_stack_err;
	logic [WN-1:0]           o_wor_image;
	logic                    o_wor_update;
	int n_mismatch;
	int total_checks;
	int seed;
	int m_stk, m_dep, m_err, m_acc, m_img, m_wv, m_wa, m_wd, m_upd;
	lrbs_instr_t r;

	lrbs_solver #(.WOR_N(WN)) dut (
		.i_clk         (i_clk),
		.i_rst_b       (i_rst_b),
		.i_instr       (i_instr),
		.o_wr          (o_wr),
		.o_rung_result (o_rung_result),
		.o_stack_depth (o_stack_depth),
		.o_stack_err   (o_stack_err),
		.o_wor_image   (o_wor_image),
		.o_wor_update  (o_wor_update)
	);

	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	task automatic cmp(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic check_all();
		cmp("result", m_stk & 1, o_rung_result);
		cmp("result", m_stk & 1, o_rung_result);
		cmp("result", m_stk & 1, o_rung_result);
		cmp("depth", m_dep, o_stack_depth);
		cmp("err", m_err, o_stack_err);
		cmp("wr_valid", m_wv, o_wr.valid);
		if (m_wv != 0) begin
			cmp("wr_addr", m_wa, o_wr.addr);
			cmp("wr_data", m_wd, o_wr.data);
		end
		cmp("wor_image", m_img, o_wor_image);
		cmp("wor_update", m_upd, o_wor_update);
	endtask

	task automatic model_step(input lrbs_instr_t x);
		int v;
		int b;
		v = x.from_word ? int'(x.word[x.bit_idx]) : int'(x.point_val);
		m_wv = 0;
		m_upd = 0;
		if (x.valid) begin
			case (x.op)
				op_rung_start: begin
					m_stk = 0;
					m_dep = 0;
					m_err = 0;
				end
				op_branch_begin_contact: begin
					m_err = m_err | (m_dep == 8);
					m_stk = ((m_stk << 1) | v) & 8'hff;
					m_dep = (m_dep == 8) ? 8 : m_dep + 1;
				end
				op_parallel_contact: m_stk = m_stk | v;
				op_parallel_inverted_contact: m_stk = m_stk | (v ^ 1);
				op_series_contact: m_stk = m_stk & (v | 8'hfe);
				op_series_inverted_contact: m_stk = m_stk & ((v ^ 1) | 8'hfe);
				op_series_branch_merge, op_parallel_branch_merge: begin
					if (x.op == op_series_branch_merge)
						b = m_stk & (m_stk >> 1) & 1;
					else
						b = (m_stk | (m_stk >> 1)) & 1;
					m_stk = ((m_stk >> 1) & 8'hfe) | b;
					m_err = m_err | (m_dep < 2);
					if (m_dep >= 2)
						m_dep = m_dep - 1;
				end
				op_coil: begin
					m_wv = 1;
					m_wa = x.addr;
					m_wd = m_stk & 1;
				end
				op_wired_or_coil: m_acc = m_acc | ((m_stk & 1) << (x.addr % WN));
				op_scan_end: begin
					m_img = m_acc;
					m_acc = 0;
					m_upd = 1;
				end
				default: ;
			endcase
		end
	endtask

	task automatic step(input lrbs_op_t op, input int pv, input int a);
		@(negedge i_clk);
		check_all();
		i_instr = '0;
		i_instr.valid = 1'b1;
		i_instr.op = op;
		i_instr.point_val = 1'(pv);
		i_instr.addr = 16'(a);
		model_step(i_instr);
	endtask

	task automatic do_reset(input int n);
		@(negedge i_clk);
		i_rst_b = 1'b0;
		i_instr = '0;
		{m_stk, m_dep, m_err, m_acc, m_img, m_wv, m_upd} = '0;
		repeat (n) @(negedge i_clk);
		check_all();
		i_rst_b = 1'b1;
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge i_clk);
		n_mismatch++;
		tally_and_finish();
	end

	initial begin
		seed = 96537;
		i_rst_b = 1'b0;
		i_instr = '0;
		do_reset(6);
		// walk: inverted contacts, wired-or, coil and scan end
		step(op_rung_start, 0, 0);
		step(op_branch_begin_contact, 1, 0);
		step(op_parallel_inverted_contact, 0, 0);
		step(op_wired_or_coil, 0, 2);
		step(op_series_inverted_contact, 1, 0);
		step(op_coil, 0, 5);
		step(op_parallel_contact, 1, 0);
		step(op_coil, 1, 5);
		step(op_scan_end, 0, 0);
		step(op_nop, 0, 0);
		// two rungs drive wired-or target 0, off then on
		step(op_rung_start, 0, 0);
		step(op_branch_begin_contact, 0, 0);
		step(op_wired_or_coil, 0, 0);
		step(op_rung_start, 0, 0);
		step(op_branch_begin_contact, 1, 0);
		step(op_wired_or_coil, 0, 0);
		step(op_scan_end, 0, 0);
		step(op_nop, 0, 0);
		$display("test walk done");
		// nine pushes overflow, then merges down to underflow
		step(op_rung_start, 0, 0);
		for (int i = 0; i < 9; i++)
			step(op_branch_begin_contact, i & 1, 0);
		for (int i = 0; i < 9; i++)
			step(i[0] ? op_series_branch_merge : op_parallel_branch_merge, 0, 0);
		step(op_rung_start, 0, 0);
		step(op_nop, 0, 0);
		$display("test stack limits done");
		for (int i = 0; i < 3000; i++) begin
			if (i == 1500)
				do_reset(2);
			r.valid = ($random(seed) & 7) != 0;
			r.op = lrbs_op_t'(4'({$random(seed)} % 12));
			r.from_word = 1'($random(seed));
			r.point_val = 1'($random(seed));
			r.word = 16'($random(seed));
			r.bit_idx = 4'($random(seed));
			r.addr = 16'($random(seed));
			@(negedge i_clk);
			check_all();
			i_instr = r;
			model_step(r);
		end
		step(op_nop, 0, 0);
		$display("test random done");
		tally_and_finish();
	end
endmodule
`default_nettype wire

// >>> hw/lrbs_pkg.sv
// constants and types for the ladder rung boolean solver
package lrbs_pkg;

	localparam int               LRBS_STACK_DEPTH = 8;
	localparam int               LRBS_DEPTH_W     = 4;
	localparam int               LRBS_WORD_W      = 16;
	localparam int               LRBS_IDX_W       = 4;
	localparam int               LRBS_ADDR_W      = 16;
	localparam int               LRBS_WOR_N       = 16;
	localparam logic [LRBS_STACK_DEPTH-1:0] LRBS_STACK_RST = 8'h00;
	localparam logic [LRBS_DEPTH_W-1:0]     LRBS_DEPTH_RST = 4'h0;
	localparam logic [LRBS_DEPTH_W-1:0]     LRBS_DEPTH_MAX = 4'h8;
	localparam logic [LRBS_DEPTH_W-1:0]     LRBS_MERGE_MIN = 4'h2;

	typedef enum logic [3:0] {
		op_nop                       = 4'h0,
		op_rung_start                = 4'h1,
		op_branch_begin_contact      = 4'h2,
		op_parallel_contact          = 4'h3,
		op_parallel_inverted_contact = 4'h4,
		op_series_contact            = 4'h5,
		op_series_inverted_contact   = 4'h6,
		op_series_branch_merge       = 4'h7,
		op_parallel_branch_merge     = 4'h8,
		op_coil                      = 4'h9,
		op_wired_or_coil             = 4'ha,
		op_scan_end                  = 4'hb
	} lrbs_op_t;

	typedef struct packed {
		logic                   valid;
		lrbs_op_t               op;
		logic                   from_word;
		logic                   point_val;
		logic [LRBS_WORD_W-1:0] word;
		logic [LRBS_IDX_W-1:0]  bit_idx;
		logic [LRBS_ADDR_W-1:0] addr;
	} lrbs_instr_t;

	typedef struct packed {
		logic                   valid;
		logic [LRBS_ADDR_W-1:0] addr;
		logic                   data;
	} lrbs_wr_t;

endpackage

// >>> hw/lrbs_solver.sv
// rung evaluator: boolean stack, contacts, merges and coils
`timescale 1ns/1ns
`default_nettype none
module lrbs_solver #(
	parameter int WOR_N = lrbs_pkg::LRBS_WOR_N
) (
	input  wire logic               i_clk,
	input  wire logic               i_rst_b,
	input  wire lrbs_pkg::lrbs_instr_t i_instr,
	output lrbs_pkg::lrbs_wr_t      o_wr,
	output logic                    o_rung_result,
	output logic [lrbs_pkg::LRBS_DEPTH_W-1:0] o_stack_depth,
	output logic                    o_stack_err,
	output logic [WOR_N-1:0]        o_wor_image,
	output logic                    o_wor_update
);
	import lrbs_pkg::*;

	localparam int WOR_AW = (WOR_N > 1) ? $clog2(WOR_N) : 1;

	// operand bit: discrete point, or one bit of a word
	function automatic logic operand_bit(input lrbs_instr_t ins);
		logic v;
		v = ins.from_word ? ins.word[ins.bit_idx] : ins.point_val;
		return v;
	endfunction

	function automatic logic is_op(input lrbs_instr_t ins,
		input lrbs_op_t op);
		logic r;
		r = ins.valid && (ins.op == op);
		return r;
	endfunction

	logic [LRBS_STACK_DEPTH-1:0] stk_reg;
	logic [LRBS_STACK_DEPTH-1:0] stk_next;
	logic [LRBS_DEPTH_W-1:0]     depth_reg;
	logic [LRBS_DEPTH_W-1:0]     depth_next;
	logic                        err_reg;
	logic                        err_next;
	lrbs_wr_t                    wr_reg;
	lrbs_wr_t                    wr_next;
	logic [WOR_N-1:0]            wacc_reg;
	logic [WOR_N-1:0]            wacc_next;
	logic [WOR_N-1:0]            wimg_reg;
	logic [WOR_N-1:0]            wimg_next;
	logic                        wupd_reg;
	logic                        wupd_next;
	logic                        opv;
	logic [WOR_AW-1:0]           widx;

	assign opv  = operand_bit(i_instr);
	assign widx = i_instr.addr[WOR_AW-1:0];

	always_comb begin
		stk_next   = stk_reg;
		depth_next = depth_reg;
		err_next   = err_reg;
		wr_next    = '0;
		wacc_next  = wacc_reg;
		wimg_next  = wimg_reg;
		wupd_next  = 1'b0;
		if (i_instr.valid) begin
			unique case (i_instr.op)
				op_nop: begin
				end
				op_rung_start: begin
					stk_next   = LRBS_STACK_RST;
					depth_next = LRBS_DEPTH_RST;
					err_next   = 1'b0;
				end
				op_branch_begin_contact: begin
					// push; bottom level falls off when full
					stk_next = {stk_reg[LRBS_STACK_DEPTH-2:0], opv};
					if (depth_reg == LRBS_DEPTH_MAX) begin
						err_next = 1'b1;
					end else begin
						depth_next = depth_reg + 4'h1;
					end
				end
				op_parallel_contact: begin
					stk_next[0] = stk_reg[0] | opv;
				end
				op_parallel_inverted_contact: begin
					stk_next[0] = stk_reg[0] | ~opv;
				end
				op_series_contact: begin
					stk_next[0] = stk_reg[0] & opv;
				end
				op_series_inverted_contact: begin
					stk_next[0] = stk_reg[0] & ~opv;
				end
				op_series_branch_merge,
				op_parallel_branch_merge: begin
					// too few levels: flag it, still combine
					if (depth_reg < LRBS_MERGE_MIN) begin
						err_next = 1'b1;
					end else begin
						depth_next = depth_reg - 4'h1;
					end
					stk_next = {1'b0, stk_reg[LRBS_STACK_DEPTH-1:2],
						(i_instr.op == op_series_branch_merge) ?
						(stk_reg[0] & stk_reg[1]) :
						(stk_reg[0] | stk_reg[1])};
				end
				op_coil: begin
					// each write issued; downstream keeps the latest
					wr_next.valid = 1'b1;
					wr_next.addr  = i_instr.addr;
					wr_next.data  = stk_reg[0];
				end
				op_wired_or_coil: begin
					wacc_next[widx] = wacc_reg[widx] | stk_reg[0];
				end
				op_scan_end: begin
					wimg_next = wacc_reg;
					wacc_next = '0;
					wupd_next = 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			stk_reg   <= LRBS_STACK_RST;
			depth_reg <= LRBS_DEPTH_RST;
			err_reg   <= 1'b0;
			wr_reg    <= '0;
			wacc_reg  <= '0;
			wimg_reg  <= '0;
			wupd_reg  <= 1'b0;
		end else begin
			stk_reg   <= stk_next;
			depth_reg <= depth_next;
			err_reg   <= err_next;
			wr_reg    <= wr_next;
			wacc_reg  <= wacc_next;
			wimg_reg  <= wimg_next;
			wupd_reg  <= wupd_next;
		end
	end

	assign o_wr          = wr_reg;
	assign o_rung_result = stk_reg[0];
	assign o_stack_depth = depth_reg;
	assign o_stack_err   = err_reg;
	assign o_wor_image   = wimg_reg;
	assign o_wor_update  = wupd_reg;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);

	sequence s_push;
		is_op(i_instr, op_branch_begin_contact);
	endsequence

	sequence s_merge_ok(lrbs_op_t op);
		is_op(i_instr, op) && (depth_reg >= LRBS_MERGE_MIN);
	endsequence

	sequence s_wor_hit;
		is_op(i_instr, op_wired_or_coil) && stk_reg[0] &&
			(widx == '0);
	endsequence

	sequence s_scan_close;
		is_op(i_instr, op_scan_end);
	endsequence

	chk_push_shift: assert property (
		s_push |=> (stk_reg[0] == $past(opv)) &&
			(stk_reg[LRBS_STACK_DEPTH-1:1] ==
			$past(stk_reg[LRBS_STACK_DEPTH-2:0])))
		else $error("branch begin did not push the stack");

	chk_depth_limit: assert property (
		depth_reg <= LRBS_DEPTH_MAX)
		else $error("stack depth above eight levels");

	chk_par_contact: assert property (
		is_op(i_instr, op_parallel_contact) |=>
			stk_reg[0] == ($past(stk_reg[0]) | $past(opv)))
		else $error("parallel contact result wrong");

	chk_par_inverted: assert property (
		is_op(i_instr, op_parallel_inverted_contact) |=>
			stk_reg[0] == ($past(stk_reg[0]) | !$past(opv)))
		else $error("parallel inverted contact result wrong");

	chk_par_bit: assert property (
		is_op(i_instr, op_parallel_contact) && i_instr.from_word &&
			i_instr.word[i_instr.bit_idx] |=> stk_reg[0])
		else $error("parallel bit contact did not turn result on");

	chk_par_inv_bit: assert property (
		is_op(i_instr, op_parallel_inverted_contact) &&
			i_instr.from_word && !i_instr.word[i_instr.bit_idx]
			|=> stk_reg[0])
		else $error("parallel inverted bit contact missed");

	chk_ser_contact: assert property (
		is_op(i_instr, op_series_contact) |=>
			stk_reg[0] == ($past(stk_reg[0]) & $past(opv)))
		else $error("series contact result wrong");

	chk_ser_inverted: assert property (
		is_op(i_instr, op_series_inverted_contact) |=>
			stk_reg[0] == ($past(stk_reg[0]) & !$past(opv)))
		else $error("series inverted contact result wrong");

	chk_ser_bit: assert property (
		is_op(i_instr, op_series_contact) && i_instr.from_word &&
			!i_instr.word[i_instr.bit_idx] |=> !stk_reg[0])
		else $error("series bit contact did not clear result");

	chk_ser_inv_bit: assert property (
		is_op(i_instr, op_series_inverted_contact) &&
			i_instr.from_word && i_instr.word[i_instr.bit_idx]
			|=> !stk_reg[0])
		else $error("series inverted bit contact missed");

	chk_and_merge: assert property (
		s_merge_ok(op_series_branch_merge) |=>
			(stk_reg[0] == ($past(stk_reg[0]) & $past(stk_reg[1]))) &&
			(depth_reg == $past(depth_reg) - 4'h1))
		else $error("series merge wrong");

	chk_or_merge: assert property (
		s_merge_ok(op_parallel_branch_merge) |=>
			(stk_reg[0] == ($past(stk_reg[0]) | $past(stk_reg[1]))) &&
			(stk_reg[1] == $past(stk_reg[2])))
		else $error("parallel merge wrong");

	chk_coil_write: assert property (
		is_op(i_instr, op_coil) |=> o_wr.valid &&
			(o_wr.addr == $past(i_instr.addr)) &&
			(o_wr.data == $past(stk_reg[0])))
		else $error("coil write missing or wrong");

	chk_coil_quiet: assert property (
		!is_op(i_instr, op_coil) |=> !o_wr.valid)
		else $error("coil write without coil instruction");

	chk_rung_clear: assert property (
		is_op(i_instr, op_rung_start) |=>
			(stk_reg == LRBS_STACK_RST) && (depth_reg == '0))
		else $error("rung start did not clear stack");

	chk_wor_apply: assert property (
		s_wor_hit ##1 (!is_op(i_instr, op_rung_start))[*1] ##0
			s_scan_close |=> o_wor_update && o_wor_image[0])
		else $error("wired-OR output not on after a driving rung");

	chk_wor_once: assert property (
		o_wor_update |-> $past(is_op(i_instr, op_scan_end)))
		else $error("wired-OR image applied outside scan end");

endmodule
`default_nettype wire
